// ==== rtl/nfc_host.sv ====
// Host sequencer that drives a byte-wide flash through its strobe pins
// Function
// R01: Command bytes strobed with command latch high
// R02: Address bytes strobed with address latch high
// R03: Chip select high when idle gives standby
// R04: Chip select ignored by device while busy
// R05: Each read strobe fall yields next byte
// R06: Write protect low blocks program and erase
// R07: Ready/busy low during every array operation
// R08: Page is 2112 bytes, block 64 pages
// R09: Address cycles one, two carry column bits
// R10: Cycles three to five carry row bits
// R11: Pin levels select command, address, data cycles
// R12: Host releases bus while reading serial data
// R13: Strobes held high during read busy
// R14: Read 00/30, column change 05/E0
// R15: Program 80/10, 85 moves column, planes 11/81
// R16: Copy-back load 00/35, program 85/10
// R17: Erase 60 row D0, identify 90
// R18: Only status or reset accepted while busy
// R19: After power-up read needs address and 30
// R20: Read confirm starts busy array transfer
// R21: Undefined codes ignored, bus floats otherwise
`timescale 1ns/100ps
`include "nfc_map.svh"
module nfc_host (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire nfc_pkg::nfc_req_s  cmd_i,
    input  wire logic               cmd_valid_i,
    output logic                    cmd_ready_o,
    input  wire logic [7:0]         wr_data_i,
    input  wire logic               wr_valid_i,
    output logic                    wr_ready_o,
    output logic [7:0]              rd_data_o,
    output logic                    rd_valid_o,
    output logic                    done_o,
    output nfc_pkg::nfc_pins_s      pins_o,
    input  wire logic [7:0]         io_i,
    input  wire logic               ready_busy_n_i
);
    import nfc_pkg::*;

    // --------------------
    // Cycle counts derived from pin timing
    // --------------------
    localparam int WB_CYC_I  = (`NFC_T_WB_NS * `NFC_CLK_MHZ + 999) / 1000;
    localparam int WHR_CYC_I = (`NFC_T_WHR_NS * `NFC_CLK_MHZ + 999) / 1000;
    localparam int WW_CYC_I  = (`NFC_T_WW_NS * `NFC_CLK_MHZ + 999) / 1000;
    localparam int CS_CYC_I  = (`NFC_T_CS_NS * `NFC_CLK_MHZ + 999) / 1000;
    localparam int REA_CYC_I = (`NFC_T_REA_NS * `NFC_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] GAP_CYC = 8'((WB_CYC_I > WHR_CYC_I) ? WB_CYC_I : WHR_CYC_I);
    localparam logic [7:0] WW_CYC  = 8'(WW_CYC_I);
    localparam logic [7:0] CS_CYC  = 8'(CS_CYC_I);
    // Spare cycle lets the bus settle before sampling
    localparam logic [7:0] RE_HOLD = 8'(REA_CYC_I + 1);

    // --------------------
    // Operation table
    // --------------------
    function automatic nfc_plan_s plan_of(input nfc_op_e op);
        nfc_plan_s p;
        p = '0;
        p.has_cmd1 = 1'b1;
        p.a_first  = `NFC_AIDX_COL_LO;
        p.a_last   = `NFC_AIDX_ROW_HI;
        case (op)
            // R14: page read sequence
            NFC_OP_READ: begin
                p.cmd1 = `NFC_CMD_READ;     p.has_addr = 1'b1; p.has_conf = 1'b1;
                p.conf = `NFC_CMD_READ_GO;  p.wait_busy = 1'b1; p.dout = 1'b1;
            end
            // R19: preloaded setup, address and 30 only
            NFC_OP_READ_QUICK: begin
                p.has_cmd1 = 1'b0;          p.has_addr = 1'b1; p.has_conf = 1'b1;
                p.conf = `NFC_CMD_READ_GO;  p.wait_busy = 1'b1; p.dout = 1'b1;
            end
            // R16: copy-back source load
            NFC_OP_COPY_LOAD: begin
                p.cmd1 = `NFC_CMD_READ;     p.has_addr = 1'b1; p.has_conf = 1'b1;
                p.conf = `NFC_CMD_COPY_GO;  p.wait_busy = 1'b1;
            end
            // R14: output column change
            NFC_OP_COL_READ: begin
                p.cmd1 = `NFC_CMD_COL_OUT;  p.has_addr = 1'b1; p.a_last = `NFC_AIDX_COL_HI;
                p.has_conf = 1'b1;          p.conf = `NFC_CMD_COL_OUT_GO; p.dout = 1'b1;
            end
            // R15: program variants
            NFC_OP_PROGRAM, NFC_OP_PLANE_FIRST, NFC_OP_PLANE_SECOND: begin
                p.cmd1 = (op == NFC_OP_PLANE_SECOND) ? `NFC_CMD_PLANE2_IN : `NFC_CMD_DATA_IN;
                p.conf = (op == NFC_OP_PLANE_FIRST) ? `NFC_CMD_PLANE_GO : `NFC_CMD_PROG_GO;
                p.has_addr = 1'b1; p.din = 1'b1; p.has_conf = 1'b1;
                p.wait_busy = 1'b1; p.wp_high = 1'b1;
            end
            // R16: copy-back program, optional data patch
            NFC_OP_COPY_PROG: begin
                p.cmd1 = `NFC_CMD_COL_IN;   p.has_addr = 1'b1; p.din = 1'b1;
                p.has_conf = 1'b1;          p.conf = `NFC_CMD_PROG_GO;
                p.wait_busy = 1'b1;         p.wp_high = 1'b1;
            end
            // R17: erase with row cycles only
            NFC_OP_ERASE: begin
                p.cmd1 = `NFC_CMD_ERASE;    p.has_addr = 1'b1; p.a_first = `NFC_AIDX_ROW_LO;
                p.has_conf = 1'b1;          p.conf = `NFC_CMD_ERASE_GO;
                p.wait_busy = 1'b1;         p.wp_high = 1'b1;
            end
            // R17: identification read, one zero address byte
            NFC_OP_READ_ID: begin
                p.cmd1 = `NFC_CMD_ID;       p.has_addr = 1'b1; p.dout = 1'b1;
                p.a_first = `NFC_AIDX_ZERO; p.a_last = `NFC_AIDX_ZERO;
            end
            NFC_OP_STATUS_MULTI: begin
                p.cmd1 = `NFC_CMD_STATUS_MP; p.dout = 1'b1;
            end
            NFC_OP_ECC_STATUS: begin
                p.cmd1 = `NFC_CMD_ECC_STATUS; p.dout = 1'b1;
            end
            NFC_OP_RESET: begin
                p.cmd1 = `NFC_CMD_RESET;    p.wait_busy = 1'b1;
            end
            // R21: status 70, also for undefined codes
            default: begin
                p.cmd1 = `NFC_CMD_STATUS;   p.dout = 1'b1;
            end
        endcase
        return p;
    endfunction

    // R09: column in cycles one and two, R10: row in three to five
    function automatic logic [7:0] addr_byte(input nfc_req_s r, input logic [2:0] i);
        case (i)
            3'd0:    addr_byte = r.col[7:0];
            3'd1:    addr_byte = {4'h0, r.col[11:8]};
            3'd2:    addr_byte = r.row[7:0];
            3'd3:    addr_byte = r.row[15:8];
            3'd4:    addr_byte = {7'h00, r.row[16]};
            default: addr_byte = 8'h00;
        endcase
    endfunction

    // --------------------
    // Sequencer
    // --------------------
    nfc_st_s    st_reg;
    nfc_st_s    st_next;
    nfc_state_e after_conf;
    nfc_state_e after_din;
    nfc_state_e after_addr;

    // Where each phase hands over, from the plan in hand
    always_comb begin
        after_conf = st_reg.plan.wait_busy ? NFC_ST_WAIT
                   : (st_reg.plan.dout ? NFC_ST_GAP : NFC_ST_DONE);
        after_din  = st_reg.plan.has_conf ? NFC_ST_CONF : after_conf;
        after_addr = st_reg.plan.din ? NFC_ST_DIN : after_din;
    end

    // Next state; every pin change lands one cycle later from the register
    always_comb begin
        st_next          = st_reg;
        st_next.io_s1    = io_i;
        st_next.io_s2    = st_reg.io_s1;
        st_next.rb_s1    = ready_busy_n_i;
        st_next.rb_s2    = st_reg.rb_s1;
        st_next.rd_valid = 1'b0;
        st_next.done     = 1'b0;
        st_next.wr_ready = 1'b0;
        case (st_reg.state)
            NFC_ST_IDLE: begin
                // R03: chip select high while idle gives standby
                st_next.pins      = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                                      re_n: 1'b1, wp_n: 1'b0, io: 8'h00, io_oe: 1'b0};
                st_next.cmd_ready = 1'b1;
                if (st_reg.cmd_ready && cmd_valid_i) begin
                    st_next.cmd_ready = 1'b0;
                    st_next.req       = cmd_i;
                    st_next.plan      = plan_of(cmd_i.op);
                    // R08: never move more than one page
                    st_next.cnt       = (cmd_i.len > `NFC_PAGE_BYTES) ? `NFC_PAGE_BYTES
                                                                     : cmd_i.len;
                    st_next.pins.ce_n = 1'b0;
                    // R06: protect lifted only for program and erase
                    st_next.pins.wp_n = st_next.plan.wp_high;
                    st_next.wcnt      = st_next.plan.wp_high ? WW_CYC : CS_CYC;
                    st_next.state     = NFC_ST_PREP;
                end
            end
            NFC_ST_PREP: begin
                st_next.aidx = st_reg.plan.a_first;
                st_next.ph   = 2'd0;
                if (st_reg.wcnt != 8'h00) begin
                    st_next.wcnt = st_reg.wcnt - 8'h01;
                end else if (st_reg.plan.has_cmd1) begin
                    st_next.state = NFC_ST_CMD1;
                end else begin
                    st_next.state = st_reg.plan.has_addr ? NFC_ST_ADDR : after_addr;
                end
            end
            NFC_ST_CMD1, NFC_ST_CONF: begin
                if (st_reg.ph == 2'd0) begin
                    // R01: R11: command cycle, latch high, strobe low
                    st_next.pins.cle   = 1'b1;
                    st_next.pins.ale   = 1'b0;
                    st_next.pins.we_n  = 1'b0;
                    st_next.pins.io_oe = 1'b1;
                    st_next.pins.io    = (st_reg.state == NFC_ST_CMD1) ? st_reg.plan.cmd1
                                                                        : st_reg.plan.conf;
                    st_next.ph         = 2'd1;
                end else begin
                    // Rising strobe latches; latch enable held one more cycle
                    st_next.pins.we_n = 1'b1;
                    st_next.ph        = 2'd0;
                    st_next.wcnt      = GAP_CYC;
                    if (st_reg.state == NFC_ST_CONF) begin
                        // R20: confirm edge starts array transfer
                        st_next.state = after_conf;
                    end else begin
                        st_next.state = st_reg.plan.has_addr ? NFC_ST_ADDR : after_addr;
                    end
                end
            end
            NFC_ST_ADDR: begin
                if (st_reg.ph == 2'd0) begin
                    // R02: address cycle, address latch high
                    st_next.pins.cle   = 1'b0;
                    st_next.pins.ale   = 1'b1;
                    st_next.pins.we_n  = 1'b0;
                    st_next.pins.io_oe = 1'b1;
                    st_next.pins.io    = addr_byte(st_reg.req, st_reg.aidx);
                    st_next.ph         = 2'd1;
                end else begin
                    st_next.pins.we_n = 1'b1;
                    st_next.ph        = 2'd0;
                    st_next.wcnt      = GAP_CYC;
                    if (st_reg.aidx == st_reg.plan.a_last) begin
                        st_next.state = after_addr;
                    end else begin
                        st_next.aidx = st_reg.aidx + 3'd1;
                    end
                end
            end
            NFC_ST_DIN: begin
                st_next.pins.cle = 1'b0;
                st_next.pins.ale = 1'b0;
                if (st_reg.ph != 2'd0) begin
                    st_next.pins.we_n = 1'b1;
                    st_next.ph        = 2'd0;
                    st_next.cnt       = st_reg.cnt - 12'h001;
                end else if (st_reg.cnt == 12'h000) begin
                    st_next.state = after_din;
                end else if (st_reg.wr_ready && wr_valid_i) begin
                    // R11: data cycle, both latches low, protect high
                    st_next.pins.we_n  = 1'b0;
                    st_next.pins.io_oe = 1'b1;
                    st_next.pins.io    = wr_data_i;
                    st_next.ph         = 2'd1;
                end else begin
                    st_next.wr_ready = 1'b1;
                end
            end
            NFC_ST_WAIT: begin
                // R13: strobes stay high while the device is busy
                st_next.pins.cle   = 1'b0;
                st_next.pins.ale   = 1'b0;
                st_next.pins.io_oe = 1'b0;
                // R04: R07: R18: chip select kept low, nothing issued until ready
                if (st_reg.wcnt != 8'h00) begin
                    st_next.wcnt = st_reg.wcnt - 8'h01;
                end else if (st_reg.rb_s2) begin
                    st_next.wcnt  = GAP_CYC;
                    st_next.state = st_reg.plan.dout ? NFC_ST_GAP : NFC_ST_DONE;
                end
            end
            NFC_ST_GAP: begin
                // R12: R21: bus released before any read strobe
                st_next.pins.cle   = 1'b0;
                st_next.pins.ale   = 1'b0;
                st_next.pins.io_oe = 1'b0;
                st_next.ph         = 2'd0;
                if (st_reg.wcnt != 8'h00) begin
                    st_next.wcnt = st_reg.wcnt - 8'h01;
                end else begin
                    st_next.state = (st_reg.cnt == 12'h000) ? NFC_ST_DONE : NFC_ST_DOUT;
                end
            end
            NFC_ST_DOUT: begin
                if (st_reg.ph == 2'd0) begin
                    st_next.pins.re_n = 1'b0;
                    st_next.wcnt      = RE_HOLD;
                    st_next.ph        = 2'd1;
                end else if (st_reg.wcnt != 8'h00) begin
                    st_next.wcnt = st_reg.wcnt - 8'h01;
                end else begin
                    // R05: one byte per strobe fall; device steps its column
                    st_next.rd_data   = st_reg.io_s2;
                    st_next.rd_valid  = 1'b1;
                    st_next.pins.re_n = 1'b1;
                    st_next.ph        = 2'd0;
                    st_next.cnt       = st_reg.cnt - 12'h001;
                    if (st_reg.cnt == 12'h001) begin
                        st_next.state = NFC_ST_DONE;
                    end
                end
            end
            NFC_ST_DONE: begin
                // R03: R06: deselect and re-protect at the end
                st_next.pins.ce_n  = 1'b1;
                st_next.pins.wp_n  = 1'b0;
                st_next.pins.io_oe = 1'b0;
                st_next.done       = 1'b1;
                st_next.state      = NFC_ST_IDLE;
            end
            default: begin
                st_next.state = NFC_ST_IDLE;
            end
        endcase
    end

    // State register; reset leaves pins idle and protected
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg           <= '0;
            st_reg.pins.ce_n <= 1'b1;
            st_reg.pins.we_n <= 1'b1;
            st_reg.pins.re_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign cmd_ready_o = st_reg.cmd_ready;
    assign wr_ready_o  = st_reg.wr_ready;
    assign rd_data_o   = st_reg.rd_data;
    assign rd_valid_o  = st_reg.rd_valid;
    assign done_o      = st_reg.done;
    assign pins_o      = st_reg.pins;

endmodule

// ==== rtl/nfc_map.svh ====
// Command codes, address layout and pin timing for the flash host sequencer
`ifndef NFC_MAP_SVH
`define NFC_MAP_SVH

// --------------------
// Command codes
// --------------------
`define NFC_CMD_READ        8'h00
`define NFC_CMD_READ_GO     8'h30
`define NFC_CMD_COPY_GO     8'h35
`define NFC_CMD_COL_OUT     8'h05
`define NFC_CMD_COL_OUT_GO  8'hE0
`define NFC_CMD_DATA_IN     8'h80
`define NFC_CMD_PLANE2_IN   8'h81
`define NFC_CMD_COL_IN      8'h85
`define NFC_CMD_PROG_GO     8'h10
`define NFC_CMD_PLANE_GO    8'h11
`define NFC_CMD_ERASE       8'h60
`define NFC_CMD_ERASE_GO    8'hD0
`define NFC_CMD_ID          8'h90
`define NFC_CMD_STATUS      8'h70
`define NFC_CMD_STATUS_MP   8'h71
`define NFC_CMD_ECC_STATUS  8'h7A
`define NFC_CMD_RESET       8'hFF

// --------------------
// Geometry and address cycle indices
// --------------------
`define NFC_COL_W           12
`define NFC_ROW_W           17
`define NFC_LEN_W           12
`define NFC_PAGE_BYTES      12'd2112
`define NFC_MAIN_BYTES      12'd2048
`define NFC_SPARE_BYTES     12'd64
`define NFC_PAGES_PER_BLOCK 7'd64
`define NFC_AIDX_COL_LO     3'd0
`define NFC_AIDX_COL_HI     3'd1
`define NFC_AIDX_ROW_LO     3'd2
`define NFC_AIDX_ROW_HI     3'd4
`define NFC_AIDX_ZERO       3'd5

// --------------------
// Timing (ns) and clock rate (MHz)
// --------------------
`define NFC_CLK_MHZ         40
`define NFC_T_WB_NS         100
`define NFC_T_WHR_NS        60
`define NFC_T_WW_NS         100
`define NFC_T_CS_NS         20
`define NFC_T_REA_NS        20

`endif

// ==== rtl/nfc_pkg.sv ====
// Types shared by the flash host sequencer and its users
`include "nfc_map.svh"
package nfc_pkg;

    // Operations the sequencer can run
    typedef enum logic [3:0] {
        NFC_OP_READ, NFC_OP_READ_QUICK, NFC_OP_COPY_LOAD, NFC_OP_COL_READ,
        NFC_OP_PROGRAM, NFC_OP_PLANE_FIRST, NFC_OP_PLANE_SECOND, NFC_OP_COPY_PROG,
        NFC_OP_ERASE, NFC_OP_READ_ID, NFC_OP_STATUS, NFC_OP_STATUS_MULTI,
        NFC_OP_ECC_STATUS, NFC_OP_RESET
    } nfc_op_e;

    typedef struct packed {
        nfc_op_e                  op;
        logic [`NFC_COL_W-1:0]    col;
        logic [`NFC_ROW_W-1:0]    row;
        logic [`NFC_LEN_W-1:0]    len;
    } nfc_req_s;

    // Flash pin drive; io_oe high while the host drives the bus
    typedef struct packed {
        logic       ce_n;
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       re_n;
        logic       wp_n;
        logic [7:0] io;
        logic       io_oe;
    } nfc_pins_s;

    typedef struct packed {
        logic       has_cmd1;
        logic [7:0] cmd1;
        logic       has_addr;
        logic [2:0] a_first;
        logic [2:0] a_last;
        logic       din;
        logic       has_conf;
        logic [7:0] conf;
        logic       wait_busy;
        logic       dout;
        logic       wp_high;
    } nfc_plan_s;

    typedef enum logic [3:0] {
        NFC_ST_IDLE, NFC_ST_PREP, NFC_ST_CMD1, NFC_ST_ADDR, NFC_ST_DIN,
        NFC_ST_CONF, NFC_ST_WAIT, NFC_ST_GAP, NFC_ST_DOUT, NFC_ST_DONE
    } nfc_state_e;

    typedef struct packed {
        nfc_state_e            state;
        nfc_plan_s             plan;
        nfc_req_s              req;
        logic [1:0]            ph;
        logic [2:0]            aidx;
        logic [`NFC_LEN_W-1:0] cnt;
        logic [7:0]            wcnt;
        logic [7:0]            io_s1;
        logic [7:0]            io_s2;
        logic                  rb_s1;
        logic                  rb_s2;
        nfc_pins_s             pins;
        logic                  cmd_ready;
        logic                  wr_ready;
        logic [7:0]            rd_data;
        logic                  rd_valid;
        logic                  done;
    } nfc_st_s;

endpackage

// ==== tb/nfc_host_assertions.sv ====
// Port checker for the flash host sequencer
`timescale 1ns/100ps
module nfc_host_assertions (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               cmd_ready_o,
    input wire logic               rd_valid_o,
    input wire nfc_pkg::nfc_pins_s pins_o,
    input wire logic               ready_busy_n_i
);
    import nfc_pkg::*;
    // --------------------
    // Pin protocol properties
    // --------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Write strobe is one cycle low, then one high
    sequence s_wpulse;
        !pins_o.we_n ##1 pins_o.we_n;
    endsequence
    property p_strobe;
        (!pins_o.we_n && (pins_o.cle || pins_o.ale))
            |-> (pins_o.cle ^ pins_o.ale) && !pins_o.ce_n && pins_o.re_n && pins_o.io_oe;
    endproperty
    property p_latch_hold;
        (!pins_o.we_n && (pins_o.cle || pins_o.ale))
            |-> s_wpulse ##0 $stable({pins_o.cle, pins_o.ale});
    endproperty
    property p_data_in;
        (!pins_o.we_n && !pins_o.cle && !pins_o.ale)
            |-> pins_o.wp_n && pins_o.io_oe && !pins_o.ce_n && pins_o.re_n;
    endproperty
    property p_wp_lead;
        $rose(pins_o.wp_n) |-> pins_o.we_n [*4];
    endproperty
    property p_dout;
        !pins_o.re_n |-> !pins_o.io_oe && !pins_o.cle && !pins_o.ale && pins_o.we_n && !pins_o.ce_n;
    endproperty
    property p_busy_quiet;
        !ready_busy_n_i [*3] |-> pins_o.we_n && pins_o.re_n;
    endproperty
    property p_rd_pulse;
        rd_valid_o |-> pins_o.re_n && !$past(pins_o.re_n);
    endproperty
    property p_reset;
        $fell(rst_i) |-> pins_o.ce_n && pins_o.we_n && pins_o.re_n && !pins_o.io_oe && !cmd_ready_o;
    endproperty
    a_strobe: assert property (p_strobe) else $error("bad latch strobe levels");
    a_latch_hold: assert property (p_latch_hold) else $error("latch strobe shape");
    a_data_in: assert property (p_data_in) else $error("data input levels");
    a_wp_lead: assert property (p_wp_lead) else $error("write protect lead");
    a_dout: assert property (p_dout) else $error("serial output levels");
    a_busy_quiet: assert property (p_busy_quiet) else $error("strobe while busy");
    a_rd_pulse: assert property (p_rd_pulse) else $error("read byte timing");
    a_reset: assert property (p_reset) else $error("pins after reset");
endmodule
bind nfc_host nfc_host_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_ready_o(cmd_ready_o), .rd_valid_o(rd_valid_o), .pins_o(pins_o),
    .ready_busy_n_i(ready_busy_n_i));

// ==== tb/nfc_flash_model.sv ====
// Behavioural flash device facing the host sequencer
`timescale 1ns/100ps
module nfc_flash_model (
    input  wire nfc_pkg::nfc_pins_s pins_i,
    input  int                      busy_ns_i,
    output logic [7:0]              io_o,
    output logic                    busy_pull_o
);
    import nfc_pkg::*;
    localparam logic [7:0]  STATUS_BYTE = 8'hE0;
    localparam logic [11:0] PAGE_LAST   = 12'h83F;
    localparam int          ACCESS_NS   = 20;
    logic [9:0]  log_q[$];
    logic [11:0] col = 12'h000;
    logic [2:0]  aix = 3'h0;
    logic        stat = 1'b0;
    int          faults = 0;
    // array read mode is the power-up mode
    initial {io_o, busy_pull_o} = 9'h000;
    // latch on strobe rise; busy drops strobes
    always @(posedge pins_i.we_n) begin
        if (!pins_i.ce_n && !busy_pull_o) begin
            log_q.push_back({pins_i.cle, pins_i.ale, pins_i.io});
            if (pins_i.cle) begin
                aix = 3'h0;
                stat = pins_i.io inside {8'h70, 8'h71, 8'h7A, 8'h90};
            end else if (pins_i.ale) begin
                // first two address cycles load the column
                if (aix == 3'h0) col[7:0] = pins_i.io;
                if (aix == 3'h1) col[11:8] = pins_i.io[3:0];
                aix = aix + 3'h1;
            end else if (!pins_i.wp_n) faults++;
            // confirms hold busy; write protect inhibits
            if (pins_i.cle && (pins_i.io inside {8'h30, 8'h35, 8'hFF}
                    || (pins_i.wp_n && pins_i.io inside {8'h10, 8'h11, 8'hD0}))) begin
                busy_pull_o = 1'b1;
                #(busy_ns_i) busy_pull_o = 1'b0;
            end
        end
    end
    // host must not strobe while busy
    always @(negedge pins_i.we_n or negedge pins_i.re_n) begin
        if (busy_pull_o && !pins_i.ce_n) faults++;
    end
    // byte after access time; column wraps at page end
    always @(negedge pins_i.re_n) begin
        #(ACCESS_NS) io_o = stat ? STATUS_BYTE : col[7:0] ^ 8'h5A;
        col = (col == PAGE_LAST) ? 12'h000 : col + 12'h001;
    end
    // released bus shows inverted last byte
    always @(posedge pins_i.re_n or posedge pins_i.ce_n) io_o = ~io_o;
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the flash host sequencer
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module testbench;
    import nfc_pkg::*;
    localparam int LIMIT = 20000;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    nfc_req_s   cmd_i = '0;
    logic       cmd_valid_i = 1'b0;
    logic       cmd_ready_o;
    logic [7:0] wr_data_i = 8'h00;
    logic       wr_valid_i = 1'b0;
    logic       wr_ready_o;
    logic [7:0] rd_data_o;
    logic       rd_valid_o;
    logic       done_o;
    nfc_pins_s  pins_o;
    logic [7:0] flash_io;
    logic       busy_pull;
    int         busy_ns = 2000;
    int         failures = 0;
    int         checks = 0;
    int         cycles = 0;
    time        t0;
    logic [7:0] w;
    logic [7:0] rd_q[$];
    // Bus level from whoever drives; ready line is the inverted model busy pull
    wire logic [7:0] io_i = pins_o.io_oe ? pins_o.io : flash_io;
    wire logic       rb_n = ~busy_pull;
    nfc_host dut_u (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i),
        .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .done_o(done_o), .pins_o(pins_o), .io_i(io_i), .ready_busy_n_i(rb_n));
    nfc_flash_model flash_u (.pins_i(pins_o), .busy_ns_i(busy_ns), .io_o(flash_io),
        .busy_pull_o(busy_pull));
    always #12.5 clk_i = ~clk_i;
    // Write stream source, read sink and hang guard
    always @(posedge clk_i) begin
        if (wr_valid_i && wr_ready_o) wr_data_i <= wr_data_i + 8'h01;
        if (rd_valid_o) rd_q.push_back(rd_data_o);
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One operation, from request to completion pulse
    task automatic run(input nfc_op_e op, input logic [11:0] col, input logic [16:0] row);
        flash_u.log_q.delete();
        rd_q.delete();
        t0 = $time;
        cmd_i <= '{op, col, row, 12'h003};
        cmd_valid_i <= 1'b1;
        do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
        cmd_valid_i <= 1'b0;
        do @(posedge clk_i); while (done_o !== 1'b1);
    endtask
    task automatic expect_log(input logic [9:0] exp[$]);
        `CHK(flash_u.log_q.size(), exp.size())
        for (int i = 0; i < exp.size(); i++) `CHK(flash_u.log_q[i], exp[i])
    endtask
    task automatic t_table();
        nfc_op_e ops[9] = '{NFC_OP_STATUS, NFC_OP_STATUS_MULTI, NFC_OP_ECC_STATUS,
            NFC_OP_READ_ID, NFC_OP_RESET, NFC_OP_COPY_LOAD, NFC_OP_PLANE_FIRST,
            NFC_OP_PLANE_SECOND, NFC_OP_COPY_PROG};
        logic [9:0] first[9] = '{10'h270, 10'h271, 10'h27A, 10'h290, 10'h2FF, 10'h200,
            10'h280, 10'h281, 10'h285};
        logic [9:0] last[9] = '{10'h270, 10'h271, 10'h27A, 10'h100, 10'h2FF, 10'h235,
            10'h211, 10'h210, 10'h210};
        for (int i = 0; i < 9; i++) begin
            run(ops[i], 12'h000, 17'h0_0040);
            `CHK(flash_u.log_q[0], first[i])
            `CHK(flash_u.log_q[$], last[i])
            if (i < 3) `CHK(rd_q[0], 8'hE0)
        end
        $display("command table done");
    endtask
    task automatic t_read();
        // Slow device; column starts two bytes before the page end
        busy_ns = 2000;
        run(NFC_OP_READ, 12'h83E, 17'h1_2345);
        expect_log('{10'h200, 10'h13E, 10'h108, 10'h145, 10'h123, 10'h101, 10'h230});
        `CHK({rd_q[0], rd_q[1], rd_q[2]}, 24'h64_655A)
        `CHK($time - t0 > busy_ns, 1'b1)
        // Prompt device, read started without the setup code
        busy_ns = 50;
        run(NFC_OP_READ_QUICK, 12'h000, 17'h0_0000);
        expect_log('{10'h100, 10'h100, 10'h100, 10'h100, 10'h100, 10'h230});
        `CHK(rd_q[0], 8'h5A)
        run(NFC_OP_COL_READ, 12'h005, 17'h0_0000);
        expect_log('{10'h205, 10'h105, 10'h100, 10'h2E0});
        `CHK({rd_q[0], rd_q[1]}, 16'h5F5C)
        $display("read done");
    endtask
    task automatic t_write();
        run(NFC_OP_ERASE, 12'h000, 17'h1_FFC0);
        expect_log('{10'h260, 10'h1C0, 10'h1FF, 10'h101, 10'h2D0});
        `CHK(pins_o.wp_n, 1'b0)
        w = wr_data_i;
        run(NFC_OP_PROGRAM, 12'h010, 17'h0_0041);
        expect_log('{10'h280, 10'h110, 10'h100, 10'h141, 10'h100, 10'h100,
            {2'b00, w}, {2'b00, w + 8'h01}, {2'b00, w + 8'h02}, 10'h210});
        `CHK(flash_u.faults, 0)
        $display("program and erase done");
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wr_valid_i <= 1'b1;
        t_table();
        t_read();
        t_write();
        test_done();
    end
endmodule
